// ### design/lane_top.sv
// lane_top: serial lane, transmit serializer, receive deserializer,
// crossing queue, delay control and automatic alignment, APB registers
// assumes every link clock is far slower than CLK_SYS and sampled by it
`timescale 1ns/10ps
module lane_top #(
	parameter int QUEUE_DEPTH = lane_pkg::QUEUE_DEPTH
) (
	// system
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// transmit side of the core
	input  wire logic [9:0]  TX_WORD,
	input  wire logic        TX_PARALLEL_WORD_CLOCK,
	input  wire logic        TX_SERIAL_BIT_CLOCK,
	input  wire logic        TX_PATH_CLEAR,
	input  wire logic        TX_OE,
	// receive side of the core
	input  wire logic        RX_PARALLEL_WORD_CLOCK,
	input  wire logic        RX_SERIAL_BIT_CLOCK,
	input  wire logic        RX_PATH_CLEAR,
	input  wire logic        CROSSING_QUEUE_READ_CLOCK,
	input  wire logic        QUEUE_READ,
	output logic      [9:0]  RX_WORD,
	output logic             QUEUE_EMPTY,
	// delay control
	input  wire logic        DELAY_ADJUST_ACTIVE,
	input  wire logic        DELAY_STEP_UP,
	input  wire logic        DELAY_ADJUST_CLEAR,
	output logic             LOCK,
	output logic      [5:0]  FINAL_TAP_REPORT,
	// pad controls
	input  wire logic        INPUT_BUFFER_ON,
	input  wire logic        TERMINATION_ON,
	output logic             BUFFER_POWERED,
	output logic             TERMINATION_ENGAGED,
	// pads
	input  wire logic        PAD_P_IN,
	output logic             PAD_P_OUT,
	output logic             PAD_N_OUT,
	output logic             PAD_OE_N
);
	localparam int QW = $clog2(QUEUE_DEPTH);
	localparam int CW = $clog2(QUEUE_DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(QUEUE_DEPTH);
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);
	localparam int            TW       = lane_pkg::TAP_W;

	function automatic logic [3:0] word_width(input logic [3:0] w);
		if (w < lane_pkg::WIDTH_MIN)
			word_width = lane_pkg::WIDTH_MIN;
		else if (w > lane_pkg::WIDTH_MAX)
			word_width = lane_pkg::WIDTH_MAX;
		else
			word_width = w;
	endfunction : word_width

	function automatic logic [QW-1:0] next_ptr(input logic [QW-1:0] ptr);
		if (ptr == QW'(QUEUE_DEPTH - 1))
			next_ptr = '0;
		else
			next_ptr = ptr + QW'(1);
	endfunction : next_ptr

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == lane_pkg::OFF_CTRL) || (a == lane_pkg::OFF_STATUS)
			|| (a == lane_pkg::OFF_RX_WORD);
	endfunction : mapped

	logic [lane_pkg::PIN_W-1:0] raw;
	logic [lane_pkg::PIN_W-1:0] lvl;
	logic [lane_pkg::PIN_W-1:0] rise;
	logic [lane_pkg::PIN_W-1:0] fall;
	lane_pkg::pins_t            p;
	lane_pkg::pins_t            e;
	lane_pkg::pins_t            f;

	assign raw = {TX_WORD, TX_PARALLEL_WORD_CLOCK, TX_SERIAL_BIT_CLOCK,
		TX_PATH_CLEAR, TX_OE, RX_PARALLEL_WORD_CLOCK, RX_SERIAL_BIT_CLOCK,
		RX_PATH_CLEAR, CROSSING_QUEUE_READ_CLOCK, QUEUE_READ, PAD_P_IN,
		DELAY_ADJUST_ACTIVE, DELAY_STEP_UP, DELAY_ADJUST_CLEAR,
		INPUT_BUFFER_ON, TERMINATION_ON};

	for (genvar i = 0; i < lane_pkg::PIN_W; i++)
	begin : g_sync
		lane_sync u_sync (
			.clk      (CLK_SYS),
			.rst      (RST),
			.async_in (raw[i]),
			.level    (lvl[i]),
			.rise     (rise[i]),
			.fall     (fall[i])
		);
	end

	assign p = lane_pkg::pins_t'(lvl);
	assign e = lane_pkg::pins_t'(rise);
	assign f = lane_pkg::pins_t'(fall);

	lane_pkg::ctrl_t        ctrl_reg;
	logic                   pready_reg;
	logic                   pslverr_reg;
	logic [31:0]            prdata_reg;
	logic [9:0]             tx_word_prev_reg;
	logic [9:0]             tx_shift_reg;
	logic [3:0]             tx_cnt_reg;
	logic                   tx_bit_reg;
	logic                   pad_p_reg;
	logic                   pad_n_reg;
	logic                   pad_oe_n_reg;
	logic [9:0]             rx_shift_reg;
	logic [9:0]             rx_prev_reg;
	logic [9:0]             rx_word_reg;
	logic [9:0]             queue_mem [QUEUE_DEPTH];
	logic [QW-1:0]          wr_ptr_reg;
	logic [QW-1:0]          rd_ptr_reg;
	logic [CW-1:0]          queue_cnt_reg;
	logic [CW-1:0]          queue_cnt_next;
	logic                   queue_empty_reg;
	logic [5:0]             tap_reg;
	logic [5:0]             final_tap_reg;
	logic [5:0]             run_start_reg;
	logic [5:0]             best_start_reg;
	logic [6:0]             run_len_reg;
	logic [6:0]             best_len_reg;
	logic [5:0]             align_centre;
	logic                   lock_reg;
	logic                   buf_reg;
	logic                   term_reg;
	lane_pkg::align_state_t align_state_reg;
	lane_pkg::status_t      status;
	logic                   access;
	logic                   tx_bit_evt;
	logic                   rx_bit_evt;
	logic                   rx_sample;
	logic                   push;
	logic                   pop;
	logic                   stable_word;
	logic [3:0]             tx_w;
	logic [3:0]             rx_w;
	logic [9:0]             rx_aligned;

	assign tx_w       = word_width(ctrl_reg.width);
	assign rx_w       = word_width(ctrl_reg.width);
	assign tx_bit_evt = e.tx_ser | (ctrl_reg.half_rate & f.tx_ser);
	assign rx_bit_evt = e.rx_ser | (ctrl_reg.half_rate & f.rx_ser);
	assign rx_sample  = p.pad_in & p.buf_on;
	assign rx_aligned = rx_shift_reg >> (lane_pkg::WIDTH_MAX - rx_w);
	assign access     = PSEL & PENABLE;

	// apb slave, one wait state
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end
		else
		begin
			pready_reg  <= access & ~pready_reg;
			pslverr_reg <= access & ~pready_reg & ~mapped(PADDR);
			if (access && !pready_reg && !PWRITE)
			begin
				if (PADDR == lane_pkg::OFF_CTRL)
					prdata_reg <= 32'(ctrl_reg);
				else if (PADDR == lane_pkg::OFF_STATUS)
					prdata_reg <= 32'(status);
				else if (PADDR == lane_pkg::OFF_RX_WORD)
					prdata_reg <= 32'(rx_word_reg);
				else
					prdata_reg <= '0;
			end
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			ctrl_reg <= lane_pkg::CTRL_RESET;
		else if (access && pready_reg && PWRITE
			&& PADDR == lane_pkg::OFF_CTRL)
			ctrl_reg <= lane_pkg::ctrl_t'(PWDATA[lane_pkg::CTRL_W-1:0]);
	end

	always_comb
	begin
		status             = '0;
		status.final_tap   = final_tap_reg;
		status.queue_level = 4'(queue_cnt_reg);
		status.queue_empty = queue_empty_reg;
		status.locked      = lock_reg;
		status.tap         = tap_reg;
	end

	// transmit serializer
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			tx_word_prev_reg <= '0;
		else
			tx_word_prev_reg <= p.tx_word;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			tx_shift_reg <= '0;
			tx_cnt_reg   <= '0;
			tx_bit_reg   <= 1'b0;
		end
		else if (e.tx_par && p.tx_clr)
		begin
			tx_shift_reg <= '0;
			tx_cnt_reg   <= '0;
			tx_bit_reg   <= 1'b0;
		end
		else if (e.tx_par)
		begin
			tx_bit_reg   <= tx_word_prev_reg[0];
			tx_shift_reg <= tx_word_prev_reg >> 1;
			tx_cnt_reg   <= tx_w - lane_pkg::WIDTH_MIN;
		end
		else if (tx_bit_evt && tx_cnt_reg != '0)
		begin
			tx_bit_reg   <= tx_shift_reg[0];
			tx_shift_reg <= tx_shift_reg >> 1;
			tx_cnt_reg   <= tx_cnt_reg - lane_pkg::WIDTH_MIN;
		end
	end

	// pad drivers
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			pad_p_reg    <= 1'b0;
			pad_n_reg    <= 1'b1;
			pad_oe_n_reg <= 1'b1;
		end
		else
		begin
			pad_p_reg    <= ctrl_reg.clk_out ? p.tx_par : tx_bit_reg;
			pad_n_reg    <= ctrl_reg.clk_out ? ~p.tx_par : ~tx_bit_reg;
			pad_oe_n_reg <= ctrl_reg.bidir ? ~p.tx_oe : 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			buf_reg  <= 1'b0;
			term_reg <= 1'b0;
		end
		else
		begin
			buf_reg  <= p.buf_on;
			term_reg <= ctrl_reg.dyn_term ? p.term_on
				: ctrl_reg.term_static;
		end
	end

	// receive deserializer
	always_ff @(posedge CLK_SYS)
	begin
		if (RST || p.rx_clr)
		begin
			rx_shift_reg <= '0;
			rx_prev_reg  <= '0;
		end
		else
		begin
			if (e.rx_par)
				rx_prev_reg <= rx_aligned;
			if (rx_bit_evt)
				rx_shift_reg <= {rx_sample, rx_shift_reg[9:1]};
		end
	end

	// crossing queue
	assign push = ctrl_reg.queue_on & e.rx_par & (queue_cnt_reg != CNT_FULL);
	assign pop  = ctrl_reg.queue_on & e.rd_clk & p.rd_en
		& (queue_cnt_reg != '0);

	always_comb
	begin
		queue_cnt_next = queue_cnt_reg;
		if (push && !pop)
			queue_cnt_next = queue_cnt_reg + CNT_ONE;
		else if (pop && !push)
			queue_cnt_next = queue_cnt_reg - CNT_ONE;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (push)
			queue_mem[wr_ptr_reg] <= rx_aligned;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST || p.rx_clr)
		begin
			wr_ptr_reg      <= '0;
			rd_ptr_reg      <= '0;
			queue_cnt_reg   <= '0;
			queue_empty_reg <= 1'b1;
			rx_word_reg     <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= next_ptr(wr_ptr_reg);
			if (pop)
			begin
				rx_word_reg <= queue_mem[rd_ptr_reg];
				rd_ptr_reg  <= next_ptr(rd_ptr_reg);
			end
			if (!ctrl_reg.queue_on && e.rx_par)
				rx_word_reg <= rx_aligned;
			queue_cnt_reg   <= queue_cnt_next;
			queue_empty_reg <= !ctrl_reg.queue_on
				|| queue_cnt_next == '0;
		end
	end

	// delay control and automatic alignment
	assign stable_word  = rx_aligned == rx_prev_reg;
	assign align_centre = (best_len_reg == '0) ? lane_pkg::TAP_ZERO
		: best_start_reg + TW'((best_len_reg - lane_pkg::RUN_ONE) >> 1);

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			tap_reg         <= lane_pkg::TAP_ZERO;
			final_tap_reg   <= lane_pkg::TAP_ZERO;
			lock_reg        <= 1'b0;
			align_state_reg <= lane_pkg::ALIGN_IDLE;
			run_len_reg     <= '0;
			best_len_reg    <= '0;
			run_start_reg   <= lane_pkg::TAP_ZERO;
			best_start_reg  <= lane_pkg::TAP_ZERO;
		end
		else if (ctrl_reg.dly_mode != lane_pkg::DLY_AUTO
			|| ctrl_reg.half_rate)
		begin
			align_state_reg <= lane_pkg::ALIGN_IDLE;
			lock_reg        <= 1'b0;
			if (e.rx_par && p.dly_clr)
				tap_reg <= lane_pkg::TAP_ZERO;
			else if (e.rx_par && p.dly_act
				&& ctrl_reg.dly_mode == lane_pkg::DLY_DYNAMIC)
			begin
				if (p.dly_up && tap_reg != lane_pkg::TAP_LAST)
					tap_reg <= tap_reg + 6'h01;
				else if (!p.dly_up && tap_reg != lane_pkg::TAP_ZERO)
					tap_reg <= tap_reg - 6'h01;
			end
		end
		else if (e.rx_par && p.dly_clr)
		begin
			tap_reg         <= lane_pkg::TAP_ZERO;
			lock_reg        <= 1'b0;
			align_state_reg <= lane_pkg::ALIGN_IDLE;
		end
		else if (e.rx_par)
		begin
			case (align_state_reg)
				lane_pkg::ALIGN_IDLE:
				begin
					if (p.dly_act)
					begin
						align_state_reg <= lane_pkg::ALIGN_SWEEP;
						tap_reg         <= lane_pkg::TAP_ZERO;
						run_len_reg     <= '0;
						best_len_reg    <= '0;
						run_start_reg   <= lane_pkg::TAP_ZERO;
						best_start_reg  <= lane_pkg::TAP_ZERO;
					end
				end
				lane_pkg::ALIGN_SWEEP:
				begin
					if (stable_word)
					begin
						if (run_len_reg == '0)
							run_start_reg <= tap_reg;
						run_len_reg <= run_len_reg + lane_pkg::RUN_ONE;
						if (run_len_reg + lane_pkg::RUN_ONE > best_len_reg)
						begin
							best_len_reg   <= run_len_reg + lane_pkg::RUN_ONE;
							best_start_reg <= (run_len_reg == '0) ? tap_reg
								: run_start_reg;
						end
					end
					else
						run_len_reg <= '0;
					if (tap_reg == lane_pkg::TAP_LAST)
					begin
						align_state_reg <= lane_pkg::ALIGN_LOCKED;
						tap_reg         <= align_centre;
						final_tap_reg   <= align_centre;
						lock_reg        <= 1'b1;
					end
					else
						tap_reg <= tap_reg + 6'h01;
				end
				default:
					align_state_reg <= lane_pkg::ALIGN_LOCKED;
			endcase
		end
	end

	assign PRDATA              = prdata_reg;
	assign PREADY              = pready_reg;
	assign PSLVERR             = pslverr_reg;
	assign RX_WORD             = rx_word_reg;
	assign QUEUE_EMPTY         = queue_empty_reg;
	assign LOCK                = lock_reg;
	assign FINAL_TAP_REPORT    = final_tap_reg;
	assign BUFFER_POWERED      = buf_reg;
	assign TERMINATION_ENGAGED = term_reg;
	assign PAD_P_OUT           = pad_p_reg;
	assign PAD_N_OUT           = pad_n_reg;
	assign PAD_OE_N            = pad_oe_n_reg;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence tx_load_seq;
		e.tx_par && !p.tx_clr && !ctrl_reg.clk_out ##1 !ctrl_reg.clk_out;
	endsequence
	sequence up_step_seq;
		e.rx_par && ctrl_reg.dly_mode == lane_pkg::DLY_DYNAMIC
			&& !ctrl_reg.half_rate && p.dly_act && p.dly_up
			&& !p.dly_clr && tap_reg != lane_pkg::TAP_LAST;
	endsequence

	chk_tx_first_bit: assert property (tx_load_seq |=>
		PAD_P_OUT == $past(tx_word_prev_reg[0], 2))
		else $error("first serial bit is not bit zero");
	chk_tx_clear: assert property (e.tx_par && p.tx_clr |=>
		tx_cnt_reg == '0 && tx_shift_reg == '0 && !tx_bit_reg)
		else $error("transmit clear did not reset serializer");
	chk_clk_mode: assert property (ctrl_reg.clk_out |=>
		PAD_P_OUT == $past(p.tx_par) && PAD_N_OUT == !PAD_P_OUT)
		else $error("reference clock not on pads");
	chk_oe_follow: assert property (ctrl_reg.bidir |=>
		PAD_OE_N == !$past(p.tx_oe))
		else $error("pad enable does not follow output enable");
	chk_buf_gate: assert property (!p.buf_on && rx_bit_evt |=>
		!rx_shift_reg[9])
		else $error("disabled input buffer passed data");
	chk_term_static: assert property (!ctrl_reg.dyn_term |=>
		TERMINATION_ENGAGED == $past(ctrl_reg.term_static))
		else $error("termination ignores static setting");
	chk_rx_direct: assert property (!ctrl_reg.queue_on && e.rx_par
		&& !p.rx_clr |=> RX_WORD == $past(rx_aligned))
		else $error("received word not delivered");
	chk_queue_empty: assert property (ctrl_reg.queue_on |=>
		QUEUE_EMPTY == (queue_cnt_reg == '0))
		else $error("empty flag disagrees with queue level");
	chk_rx_clear: assert property (p.rx_clr |=>
		queue_cnt_reg == '0 && rx_shift_reg == '0 && QUEUE_EMPTY)
		else $error("receive clear left data behind");
	chk_dyn_step: assert property (up_step_seq |=>
		tap_reg == $past(tap_reg) + 6'h01)
		else $error("delay did not step up");
	chk_dly_clear: assert property (e.rx_par && p.dly_clr |=>
		tap_reg == lane_pkg::TAP_ZERO && !LOCK)
		else $error("delay clear ignored");
	chk_lock_report: assert property ($rose(LOCK) |->
		FINAL_TAP_REPORT == tap_reg
		&& $past(align_state_reg) == lane_pkg::ALIGN_SWEEP)
		else $error("lock without matching tap report");
	chk_half_no_lock: assert property (ctrl_reg.half_rate |=>
		!LOCK)
		else $error("alignment locked in half rate");
endmodule : lane_top

// ### design/lane_pkg.sv
// lane_pkg: constants, register layout and carrier types of the serial lane
// assumes one system clock and a 32-bit APB register slave
package lane_pkg;
	localparam int         WORD_W      = 10;
	localparam int         TAP_W       = 6;
	localparam int         RUN_W       = TAP_W + 1;
	localparam int         QUEUE_DEPTH = 8;
	localparam int         DATA_W      = 32;
	localparam int         ADDR_W      = 8;
	localparam logic [3:0] WIDTH_MIN   = 4'h1;
	localparam logic [3:0] WIDTH_MAX   = 4'hA;
	localparam logic [5:0] TAP_ZERO    = 6'h00;
	localparam logic [5:0] TAP_LAST    = 6'h3F;
	localparam logic [6:0] RUN_ONE     = 7'h01;
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_RX_WORD = 8'h08;

	typedef enum logic [1:0] {
		DLY_STATIC  = 2'b00,
		DLY_DYNAMIC = 2'b01,
		DLY_AUTO    = 2'b10
	} delay_mode_t;

	typedef enum logic [1:0] {
		ALIGN_IDLE   = 2'b00,
		ALIGN_SWEEP  = 2'b01,
		ALIGN_LOCKED = 2'b10
	} align_state_t;

	typedef struct packed {
		logic        term_static;
		logic        bidir;
		logic        dyn_term;
		logic        queue_on;
		delay_mode_t dly_mode;
		logic [3:0]  width;
		logic        half_rate;
		logic        clk_out;
	} ctrl_t;

	localparam int    CTRL_W     = $bits(ctrl_t);
	localparam ctrl_t CTRL_RESET = ctrl_t'(12'h420);

	typedef struct packed {
		logic [5:0] final_tap;
		logic [3:0] queue_level;
		logic       queue_empty;
		logic       locked;
		logic [5:0] tap;
	} status_t;

	localparam int STATUS_W = $bits(status_t);

	typedef struct packed {
		logic [9:0] tx_word;
		logic       tx_par;
		logic       tx_ser;
		logic       tx_clr;
		logic       tx_oe;
		logic       rx_par;
		logic       rx_ser;
		logic       rx_clr;
		logic       rd_clk;
		logic       rd_en;
		logic       pad_in;
		logic       dly_act;
		logic       dly_up;
		logic       dly_clr;
		logic       buf_on;
		logic       term_on;
	} pins_t;

	localparam int PIN_W = $bits(pins_t);
endpackage : lane_pkg

// ### design/lane_sync.sv
// lane_sync: two-flop synchroniser with edge detection for one pin
// assumes the pin is asynchronous to clk; outputs lag the pin by two edges
`timescale 1ns/10ps
module lane_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// pin and result
	input  wire logic async_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic stable_reg;
	logic prev_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_reg   <= 1'b0;
			stable_reg <= 1'b0;
			prev_reg   <= 1'b0;
		end
		else
		begin
			meta_reg   <= async_in;
			stable_reg <= meta_reg;
			prev_reg   <= stable_reg;
		end
	end

	assign level = stable_reg;
	assign rise  = stable_reg & ~prev_reg;
	assign fall  = ~stable_reg & prev_reg;
endmodule : lane_sync

// ### sim/lane_remote.sv
// lane_remote: far-end device on the lane's P pad and its output enable
// assumes the tx link clocks come from the bench's core side
`timescale 1ns/10ps
module lane_remote (
	// from the lane, plus the bench's tx bit clock
	input  wire logic       tx_fast,
	input  wire logic       pad_p,
	input  wire logic       pad_oe_n,
	// to the lane
	output logic            rx_fast,
	output logic            rx_slow,
	output logic            pad_in,
	// word seen on the pads
	output logic      [9:0] got
);
	logic drv;

	initial
	begin
		rx_fast = 1'b0;
		rx_slow = 1'b0;
		drv = 1'b0;
		got = 10'h000;
	end

	// shared pad: lane level while it drives, else remote data
	assign pad_in = pad_oe_n ? drv : pad_p;

	// sample late in the bit, first bit ends in bit zero
	always @(posedge tx_fast)
	begin
		#10;
		got = {pad_p, got[9:1]};
	end

	// one word: eleven bit clocks, slow rise on the eleventh
	task send(input logic [9:0] w);
		for (int i = 0; i < 11; i++)
		begin
			drv <= (i < 10) ? w[i] : ~drv;
			#50;
			rx_fast <= 1'b1;
			rx_slow <= (i == 10);
			#100;
			rx_fast <= 1'b0;
			rx_slow <= 1'b0;
			#50;
		end
	endtask : send
endmodule : lane_remote

// ### sim/lane_top_tb_top.sv
// lane_top_tb_top: self-checking bench of the serial lane
// assumes lane_remote as far end and APB register access
`timescale 1ns/10ps
module lane_top_tb_top;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [9:0]  tx_word, rx_word, got;
	logic        tx_slow, tx_fast, tx_clr, tx_oe, rx_slow, rx_fast;
	logic        rx_clr, rd_clk, rd_en, empty, act, up, dclr, lock;
	logic [5:0]  ftap;
	logic        buf_on, term_on, powered, engaged, pad_in;
	logic        pad_p, pad_n, oe_n;
	logic [8:0]  dtab [6];
	int          bad_count, tests_run;

	lane_top u_lane_top (
		.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TX_WORD(tx_word), .TX_PARALLEL_WORD_CLOCK(tx_slow),
		.TX_SERIAL_BIT_CLOCK(tx_fast), .TX_PATH_CLEAR(tx_clr),
		.TX_OE(tx_oe), .RX_PARALLEL_WORD_CLOCK(rx_slow),
		.RX_SERIAL_BIT_CLOCK(rx_fast), .RX_PATH_CLEAR(rx_clr),
		.CROSSING_QUEUE_READ_CLOCK(rd_clk), .QUEUE_READ(rd_en),
		.RX_WORD(rx_word), .QUEUE_EMPTY(empty),
		.DELAY_ADJUST_ACTIVE(act), .DELAY_STEP_UP(up),
		.DELAY_ADJUST_CLEAR(dclr), .LOCK(lock),
		.FINAL_TAP_REPORT(ftap), .INPUT_BUFFER_ON(buf_on),
		.TERMINATION_ON(term_on), .BUFFER_POWERED(powered),
		.TERMINATION_ENGAGED(engaged), .PAD_P_IN(pad_in),
		.PAD_P_OUT(pad_p), .PAD_N_OUT(pad_n), .PAD_OE_N(oe_n)
	);

	lane_remote u_lane_remote (
		.tx_fast(tx_fast), .pad_p(pad_p), .pad_oe_n(oe_n),
		.rx_fast(rx_fast), .rx_slow(rx_slow), .pad_in(pad_in),
		.got(got)
	);

	always #12.5 clk = ~clk;

	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task tx_frame(input logic [9:0] w);
		tx_word <= w;
		wt(4);
		for (int i = 0; i < 11; i++)
		begin
			tx_fast <= 1'b1;
			tx_slow <= (i == 0);
			wt(4);
			tx_fast <= 1'b0;
			tx_slow <= 1'b0;
			wt(4);
		end
	endtask : tx_frame

	task pop();
		rd_en <= 1'b1;
		wt(2);
		rd_clk <= 1'b1;
		wt(6);
		rd_clk <= 1'b0;
		rd_en <= 1'b0;
		wt(2);
	endtask : pop

	initial
	begin
		#500000;
		bad_count++;
		end_of_test();
	end

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{tx_word, tx_slow, tx_fast, tx_clr, tx_oe} = '0;
		{rx_clr, rd_clk, rd_en, act, up, dclr, term_on} = '0;
		buf_on = 1'b1;
		bad_count = 0;
		tests_run = 0;
		// delay steps: active, up, clear, expected tap
		dtab = '{9'h181, 9'h182, 9'h101, 9'h081, 9'h040, 9'h100};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h420, rdat);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped", 32'h1, rerr);
		apb(1'b1, 8'h04, 32'hFFFFFFFF);
		apb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h80, rdat);
		apb(1'b1, 8'h00, 32'h428);
		tx_oe <= 1'b1;
		tx_frame(10'h2D5);
		chk("tx word", 32'h2D5, got);
		chk("pad pair", 32'h1, pad_p ^ pad_n);
		chk("oe drive", 32'h0, oe_n);
		tx_clr <= 1'b1;
		tx_frame(10'h3FF);
		chk("tx cleared", 32'h0, got);
		tx_oe <= 1'b0;
		wt(6);
		chk("oe float", 32'h1, oe_n);
		u_lane_remote.send(10'h1B4);
		wt(6);
		chk("rx word", 32'h1B4, rx_word);
		apb(1'b0, 8'h08, 32'h0);
		chk("rx reg", 32'h1B4, rdat);
		tx_clr <= 1'b0;
		buf_on <= ~buf_on;
		wt(6);
		chk("buffer off", 32'h0, powered);
		u_lane_remote.send(10'h3FF);
		wt(6);
		chk("muted word", 32'h0, rx_word);
		buf_on <= ~buf_on;
		wt(6);
		chk("buffer on", 32'h1, powered);
		apb(1'b1, 8'h00, 32'h468);
		for (int i = 0; i < 6; i++)
		begin
			{act, up, dclr} <= dtab[i][8:6];
			wt(2);
			u_lane_remote.send(10'h2A5);
			wt(6);
			apb(1'b0, 8'h04, 32'h0);
			chk("delay tap", dtab[i][5:0], rdat[5:0]);
		end
		{act, up, dclr} <= 3'h0;
		chk("no lock", 32'h0, {ftap, lock});
		// auto alignment: one entry edge, then a sweep of all 64 taps
		apb(1'b1, 8'h00, 32'h4A8);
		act <= 1'b1;
		wt(2);
		repeat (65) u_lane_remote.send(10'h2A5);
		act <= 1'b0;
		wt(6);
		chk("lock", 32'h1, lock);
		chk("final tap", 32'h1F, ftap);
		apb(1'b1, 8'h00, 32'h4AA);
		wt(2);
		chk("half rate lock", 32'h0, lock);
		chk("tap held", 32'h1F, ftap);
		apb(1'b1, 8'h00, 32'h628);
		term_on <= ~term_on;
		wt(6);
		chk("term on", 32'h1, engaged);
		term_on <= ~term_on;
		wt(6);
		chk("term off", 32'h0, engaged);
		apb(1'b1, 8'h00, 32'h528);
		wt(2);
		chk("queue empty", 32'h1, empty);
		u_lane_remote.send(10'h0C3);
		u_lane_remote.send(10'h13C);
		wt(6);
		chk("queue held", 32'h0, empty);
		pop();
		chk("pop first", 32'h0C3, rx_word);
		pop();
		chk("pop second", 32'h13C, rx_word);
		chk("queue drained", 32'h1, empty);
		u_lane_remote.send(10'h155);
		wt(6);
		chk("queue refilled", 32'h0, empty);
		rx_clr <= 1'b1;
		wt(8);
		chk("queue cleared", 32'h1, empty);
		rx_clr <= 1'b0;
		apb(1'b1, 8'h00, 32'h429);
		tx_slow <= 1'b1;
		wt(6);
		chk("ref clock high", 32'h1, pad_p);
		tx_slow <= 1'b0;
		wt(6);
		chk("ref clock low", 32'h0, pad_p);
		end_of_test();
	end
endmodule : lane_top_tb_top
